// ---- thermal_sensor_status.sv ----
// Per-core digital thermal sensor status, thresholds and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module thermal_sensor_status #(
  parameter int         THRESH_COUNT = thermal_pkg::ID_THRESH_COUNT,
  parameter logic [3:0] RESOLUTION   = thermal_pkg::RESOLUTION_DEG
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Sensor outputs, on core_clk
  input  wire logic        sensor_hot,
  input  wire logic        critical_temp,
  input  wire logic [6:0]  readout,
  input  wire logic        readout_valid,
  // Platform pins and configuration, asynchronous
  input  wire logic        ext_hot_pin,
  input  wire logic        force_power_reduce_pin,
  input  wire logic        bidir_hot_enable,
  // Model-specific register access
  input  wire logic        msr_rd_en,
  input  wire logic        msr_wr_en,
  input  wire logic [1:0]  msr_sel,
  input  wire logic [63:0] msr_wdata,
  output var  logic [63:0] msr_rdata,
  output var  logic        msr_rd_valid,
  output var  logic        msr_fault,
  // Local vector table thermal mask
  input  wire logic        lvt_mask_wr_en,
  input  wire logic        lvt_mask_wdata,
  output var  logic        lvt_thermal_masked,
  // Identification leaf fields
  output var  logic        id_sensor_present,
  output var  logic [3:0]  id_thresh_count,
  // Shared thermal interrupt, one cycle
  output var  logic        thermal_irq
);

  // Elaboration check: the control word only holds two thresholds
  if (THRESH_COUNT < 0 || THRESH_COUNT > 2) begin : g_bad_count
    $error("THRESH_COUNT must be 0 to 2");
  end

  // ==========================================================================
  // Pin synchronisers and edge history
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_prev_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {bidir_hot_enable, force_power_reduce_pin, ext_hot_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  wire ext_hot   = pin_sync_reg[0];
  wire ext_force = pin_sync_reg[1];
  wire bidir_on  = pin_sync_reg[2];
  wire hot_rise  = ext_hot & ~pin_prev_reg[0];
  wire force_rise = ext_force & ~pin_prev_reg[1];

  // ==========================================================================
  // Control register
  logic [63:0] control_reg;
  wire  wr_status  = msr_wr_en & (msr_sel == thermal_pkg::SEL_STATUS);
  wire  wr_control = msr_wr_en & (msr_sel == thermal_pkg::SEL_CONTROL);
  wire  [63:0] control_next = msr_wdata & thermal_pkg::CT_WRITE_MASK;

  // (R16) (R17) Enables default off
  always_ff @(posedge core_clk) begin
    if (reset) begin
      control_reg <= thermal_pkg::CT_RESET;
    end else if (wr_control) begin
      control_reg <= control_next;
    end
  end

  wire [6:0] th1_value = control_reg[thermal_pkg::CT_TH1_LO +: thermal_pkg::READ_W];
  wire [6:0] th2_value = control_reg[thermal_pkg::CT_TH2_LO +: thermal_pkg::READ_W];

  // ==========================================================================
  // Live status terms
  // (R8) (R10) Lower readout means hotter
  wire th1_hit = readout_valid & (readout <= th1_value) & (THRESH_COUNT >= 1);
  wire th2_hit = readout_valid & (readout <= th2_value) & (THRESH_COUNT >= 2);
  // (R5) Hot pin counts only when bidirectional feature on
  wire ext_live = (ext_hot & bidir_on) | ext_force;

  logic hot_prev_reg;
  logic crit_prev_reg;
  logic th1_prev_reg;
  logic th2_prev_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hot_prev_reg  <= 1'b0;
      crit_prev_reg <= 1'b0;
      th1_prev_reg  <= 1'b0;
      th2_prev_reg  <= 1'b0;
    end else begin
      hot_prev_reg  <= sensor_hot;
      crit_prev_reg <= critical_temp;
      th1_prev_reg  <= th1_hit;
      th2_prev_reg  <= th2_hit;
    end
  end

  // ==========================================================================
  // Sticky log flags, cleared by a zero write
  // (R24) Writing one leaves a flag as it is
  wire [4:0] log_set = {th2_hit, th1_hit, critical_temp, ext_live, sensor_hot};
  wire [4:0] log_clr = {5{wr_status}} & ~{msr_wdata[thermal_pkg::ST_TH2_LOG],
                                          msr_wdata[thermal_pkg::ST_TH1_LOG],
                                          msr_wdata[thermal_pkg::ST_CRIT_LOG],
                                          msr_wdata[thermal_pkg::ST_EXT_LOG],
                                          msr_wdata[thermal_pkg::ST_HOT_LOG]};
  logic [4:0] log_q;

  // (R3) (R5) (R7) (R9) (R11) Sticky history bits
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_log
      log_flag u_log (
        .core_clk (core_clk),
        .reset    (reset),
        .set      (log_set[gi]),
        .clear    (log_clr[gi]),
        .flag     (log_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Status word assembly
  logic [63:0] status_word;
  always_comb begin
    status_word = 64'h0000_0000_0000_0000;
    // (R2) Live hot mirror
    status_word[thermal_pkg::ST_HOT]      = sensor_hot;
    status_word[thermal_pkg::ST_HOT_LOG]  = log_q[0];
    // (R4) External pin activity
    status_word[thermal_pkg::ST_EXT]      = ext_hot | ext_force;
    status_word[thermal_pkg::ST_EXT_LOG]  = log_q[1];
    // (R6) Critical detector
    status_word[thermal_pkg::ST_CRIT]     = critical_temp;
    status_word[thermal_pkg::ST_CRIT_LOG] = log_q[2];
    status_word[thermal_pkg::ST_TH1]      = th1_hit;
    status_word[thermal_pkg::ST_TH1_LOG]  = log_q[3];
    status_word[thermal_pkg::ST_TH2]      = th2_hit;
    status_word[thermal_pkg::ST_TH2_LOG]  = log_q[4];
    // (R12) (R13) (R14) Readout, resolution and valid
    status_word[thermal_pkg::ST_READ_LO +: thermal_pkg::READ_W] = readout;
    status_word[thermal_pkg::ST_RES_LO +: 4] = RESOLUTION;
    status_word[thermal_pkg::ST_VALID]    = readout_valid;
  end

  // ==========================================================================
  // Register read port, answer one cycle after request
  wire sel_ok = (msr_sel == thermal_pkg::SEL_STATUS) | (msr_sel == thermal_pkg::SEL_CONTROL);
  wire [63:0] read_mux = (msr_sel == thermal_pkg::SEL_STATUS)  ? status_word :
                         (msr_sel == thermal_pkg::SEL_CONTROL) ? control_reg :
                         64'h0000_0000_0000_0000;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      msr_rdata    <= 64'h0000_0000_0000_0000;
      msr_rd_valid <= 1'b0;
      msr_fault    <= 1'b0;
    end else begin
      msr_rdata    <= msr_rd_en ? read_mux : msr_rdata;
      msr_rd_valid <= msr_rd_en;
      msr_fault    <= (msr_rd_en | msr_wr_en) & ~sel_ok;
    end
  end

  // ==========================================================================
  // Interrupt sources, all share one line
  // (R16) (R17) Hot output transitions
  wire ev_high  = control_reg[thermal_pkg::CT_HIGH_EN] & sensor_hot & ~hot_prev_reg;
  wire ev_low   = control_reg[thermal_pkg::CT_LOW_EN] & ~sensor_hot & hot_prev_reg;
  // (R18) Pin events, hot pin only when bidirectional
  wire ev_pin   = (control_reg[thermal_pkg::CT_HOTPIN_EN] & bidir_on & hot_rise) |
                  (control_reg[thermal_pkg::CT_FORCE_EN] & force_rise);
  // (R19) Critical detector rising
  wire ev_crit  = control_reg[thermal_pkg::CT_CRIT_EN] & critical_temp & ~crit_prev_reg;
  // (R20) (R21) Threshold crossings either way, inverted enables
  wire ev_th1   = ~control_reg[thermal_pkg::CT_TH1_DIS] & (th1_hit ^ th1_prev_reg);
  wire ev_th2   = ~control_reg[thermal_pkg::CT_TH2_DIS] & (th2_hit ^ th2_prev_reg);
  wire ev_any   = ev_high | ev_low | ev_pin | ev_crit | ev_th1 | ev_th2;

  // (R23) Vector entry masked from reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lvt_thermal_masked <= 1'b1;
    end else if (lvt_mask_wr_en) begin
      lvt_thermal_masked <= lvt_mask_wdata;
    end
  end

  // (R22) Single shared interrupt pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      thermal_irq <= 1'b0;
    end else begin
      thermal_irq <= ev_any & ~lvt_thermal_masked;
    end
  end

  // ==========================================================================
  // Identification leaf outputs
  // (R1) Presence and threshold count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      id_sensor_present <= 1'b0;
      id_thresh_count   <= 4'h0;
    end else begin
      id_sensor_present <= 1'b1;
      id_thresh_count   <= 4'(THRESH_COUNT);
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_zero_write_hot;
    wr_status && !msr_wdata[thermal_pkg::ST_HOT_LOG] && !sensor_hot;
  endsequence

  // Pin events count only on the synchronised rising edge
  sequence s_force_event;
    control_reg[thermal_pkg::CT_FORCE_EN] && force_rise && !lvt_thermal_masked;
  endsequence

  // Hot pin events also need the bidirectional feature
  sequence s_hotpin_event;
    control_reg[thermal_pkg::CT_HOTPIN_EN] && bidir_on && hot_rise && !lvt_thermal_masked;
  endsequence

  a_hot_mirror: assert property (status_word[0] == sensor_hot) // (R2)
    else $error("hot status not live");
  a_hot_log_set: assert property (sensor_hot |=> log_q[0]) // (R3)
    else $error("hot log not set");
  a_hot_log_clear: assert property (s_zero_write_hot |=> !log_q[0]) // (R3)
    else $error("hot log not cleared");
  a_ext_log_gate: assert property ( // (R5)
      (!bidir_on && !ext_force && !log_q[1] && !wr_status) |=> !log_q[1])
    else $error("ext log set without source");
  a_crit_sticky: assert property (log_q[2] && !log_clr[2] |=> log_q[2]) // (R7)
    else $error("critical log dropped");
  a_th1_compare: assert property ( // (R8)
      status_word[6] == (readout_valid && readout <= th1_value))
    else $error("first threshold status wrong");
  a_ctrl_write: assert property ( // (R20)
      wr_control |=> control_reg == $past(control_next))
    else $error("control write lost");
  a_th2_irq: assert property ( // (R21)
      (th2_hit != th2_prev_reg) && !control_reg[23] && !lvt_thermal_masked
      |=> thermal_irq)
    else $error("second threshold interrupt missed");
  a_mask_blocks: assert property (lvt_thermal_masked |=> !thermal_irq) // (R23)
    else $error("interrupt while masked");
  a_one_keeps: assert property ( // (R24)
      wr_status && msr_wdata[thermal_pkg::ST_TH1_LOG] && log_q[3] |=> log_q[3])
    else $error("one write cleared log");
  a_read_answer: assert property ( // (R21)
      msr_rd_en && msr_sel == thermal_pkg::SEL_CONTROL |=> msr_rd_valid
      && msr_rdata == $past(control_reg))
    else $error("control read wrong");

  // Live status mirrors
  a_ext_status: assert property ( // (R4)
      status_word[thermal_pkg::ST_EXT] == (ext_hot || ext_force))
    else $error("external pin status wrong");
  a_crit_status: assert property ( // (R6)
      status_word[thermal_pkg::ST_CRIT] == critical_temp)
    else $error("critical status wrong");

  // Sticky threshold logs
  a_th1_log_set: assert property (th1_hit |=> log_q[3]) // (R9)
    else $error("first threshold log not set");
  a_th2_sticky: assert property (log_q[4] && !log_clr[4] |=> log_q[4]) // (R11)
    else $error("second threshold log dropped");

  // Interrupt paths, each reaches the shared line one cycle later
  a_high_irq: assert property ( // (R16)
      control_reg[thermal_pkg::CT_HIGH_EN] && sensor_hot && !hot_prev_reg
      && !lvt_thermal_masked |=> thermal_irq)
    else $error("high temperature interrupt missed");
  a_low_irq: assert property ( // (R17)
      control_reg[thermal_pkg::CT_LOW_EN] && !sensor_hot && hot_prev_reg
      && !lvt_thermal_masked |=> thermal_irq)
    else $error("low temperature interrupt missed");
  a_force_irq: assert property (s_force_event |=> thermal_irq) // (R18)
    else $error("force pin interrupt missed");
  a_hotpin_irq: assert property (s_hotpin_event |=> thermal_irq) // (R18)
    else $error("hot pin interrupt missed");
  a_crit_irq: assert property ( // (R19)
      control_reg[thermal_pkg::CT_CRIT_EN] && critical_temp && !crit_prev_reg
      && !lvt_thermal_masked |=> thermal_irq)
    else $error("critical interrupt missed");
  a_th1_irq: assert property ( // (R20)
      (th1_hit != th1_prev_reg) && !control_reg[thermal_pkg::CT_TH1_DIS]
      && !lvt_thermal_masked |=> thermal_irq)
    else $error("first threshold interrupt missed");

endmodule : thermal_sensor_status
`default_nettype wire

// ---- thermal_pkg.sv ----
// Constants shared by the thermal sensor readout block
//
// Notes on behaviour
// (R1) Identification leaf reports sensor present and number of usable thresholds.
// (R2) Current-hot status bit mirrors live sensor hot output; writes ignored.
// (R3) Hot history bit sets on hot output; cleared by reset or zero write.
// (R4) External-pin status bit is high while hot or force-reduce pin driven.
// (R5) External-pin log sticks on either pin; hot pin counts only if bidirectional.
// (R6) Critical status bit follows the critical detector output.
// (R7) Critical log sticks once critical asserted; cleared by reset or zero write.
// (R8) First threshold status is one while readout is at most first threshold.
// (R9) First threshold log sticks once reached; cleared by reset or zero write.
// (R10) Second threshold status is one while temperature is at or above it.
// (R11) Second threshold log sticks once reached; cleared by reset or zero write.
// (R12) Readout field gives degrees below activation point, zero at the point.
// (R13) Resolution field reports sensor tolerance in degrees, read only.
// (R14) Valid bit is set only while readout holds a valid measurement.
// (R15) Software keeps new thresholds resolution plus one degree from temperature.
// (R16) Control bit 0 enables interrupt on low-to-high transition; resets to zero.
// (R17) Control bit 1 enables interrupt on high-to-low transition; resets to zero.
// (R18) Bits 2 and 3 enable external hot-pin and force-reduce-pin interrupts.
// (R19) Control bit 4 enables the critical temperature interrupt.
// (R20) Bits 14:8 first threshold; bit 15 low enables crossing interrupt.
// (R21) Bits 22:16 second threshold; bit 23 low enables crossing interrupt.
// (R22) Interrupts go out one shared line; software reads flags for the source.
// (R23) Thermal vector entry starts masked after reset until software unmasks.
// (R24) Writing one to a log flag leaves it; read-only bits ignore writes.
package thermal_pkg;

  // ==========================================================================
  // Register selection and widths
  localparam int           DATA_W        = 64;
  localparam int           READ_W        = 7;
  localparam logic [1:0]   SEL_STATUS    = 2'h0;
  localparam logic [1:0]   SEL_CONTROL   = 2'h1;

  // ==========================================================================
  // Status field positions
  localparam int ST_HOT        = 0;
  localparam int ST_HOT_LOG    = 1;
  localparam int ST_EXT        = 2;
  localparam int ST_EXT_LOG    = 3;
  localparam int ST_CRIT       = 4;
  localparam int ST_CRIT_LOG   = 5;
  localparam int ST_TH1        = 6;
  localparam int ST_TH1_LOG    = 7;
  localparam int ST_TH2        = 8;
  localparam int ST_TH2_LOG    = 9;
  localparam int ST_READ_LO    = 16;
  localparam int ST_RES_LO     = 27;
  localparam int ST_VALID      = 31;

  // ==========================================================================
  // Control field positions and reset value
  localparam int CT_HIGH_EN    = 0;
  localparam int CT_LOW_EN     = 1;
  localparam int CT_HOTPIN_EN  = 2;
  localparam int CT_FORCE_EN   = 3;
  localparam int CT_CRIT_EN    = 4;
  localparam int CT_TH1_LO     = 8;
  localparam int CT_TH1_DIS    = 15;
  localparam int CT_TH2_LO     = 16;
  localparam int CT_TH2_DIS    = 23;
  localparam logic [63:0] CT_WRITE_MASK = 64'h0000_0000_00FF_FF1F;
  localparam logic [63:0] CT_RESET      = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // Identification leaf and sensor defaults
  localparam int          ID_THRESH_COUNT = 2;
  localparam logic [3:0]  RESOLUTION_DEG  = 4'h1;

endpackage : thermal_pkg

// ---- log_flag.sv ----
// Sticky log flag with set priority over software zero-write clear
`timescale 1ns/10ps
`default_nettype none
module log_flag (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clear,
  output var  logic flag
);

  // ==========================================================================
  // Sticky bit: set wins over clear, writing one does nothing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule : log_flag
`default_nettype wire

// ---- platform_agent.sv ----
// Model of an outside platform agent that drives the thermal pins
`timescale 1ns/10ps
`default_nettype none
module platform_agent (
  input  wire logic core_clk,
  input  wire logic hot_req,
  input  wire logic force_req,
  output var  logic ext_hot_pin,
  output var  logic force_power_reduce_pin
);
  // ==========================================================================
  // Pin drive
  // Pins move just after an edge, with no relation to the block's state
  always_ff @(posedge core_clk) begin
    ext_hot_pin            <= hot_req;
    force_power_reduce_pin <= force_req;
  end
endmodule : platform_agent
`default_nettype wire

// ---- tb_digital_thermal_sensor_status.sv ----
// Self-checking testbench for the thermal sensor status block
`timescale 1ns/10ps
`default_nettype none
module tb_digital_thermal_sensor_status;
  localparam logic [1:0]  ST  = thermal_pkg::SEL_STATUS;
  localparam logic [1:0]  CT  = thermal_pkg::SEL_CONTROL;
  localparam logic [63:0] RES = 64'(thermal_pkg::RESOLUTION_DEG) << thermal_pkg::ST_RES_LO;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        sensor_hot = 1'b0;
  logic        critical_temp = 1'b0;
  logic [6:0]  readout = 7'h00;
  logic        readout_valid = 1'b0;
  logic        hot_req = 1'b0;
  logic        force_req = 1'b0;
  logic        bidir_hot_enable = 1'b0;
  logic        msr_rd_en = 1'b0;
  logic        msr_wr_en = 1'b0;
  logic [1:0]  msr_sel = 2'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic        lvt_mask_wr_en = 1'b0;
  logic        lvt_mask_wdata = 1'b1;
  logic        ext_hot_pin, force_power_reduce_pin, msr_rd_valid, msr_fault;
  logic        lvt_thermal_masked, id_sensor_present, thermal_irq;
  logic [3:0]  id_thresh_count;
  logic [63:0] msr_rdata, rd_data;
  logic        rd_vld, rd_flt;
  int          num_errors = 0;
  int          cmp_count = 0;

  // Clock
  always #12.5 core_clk = ~core_clk;

  platform_agent i_agent (.core_clk(core_clk), .hot_req(hot_req), .force_req(force_req),
    .ext_hot_pin(ext_hot_pin), .force_power_reduce_pin(force_power_reduce_pin));

  thermal_sensor_status i_dut (.core_clk(core_clk), .reset(reset), .sensor_hot(sensor_hot),
    .critical_temp(critical_temp), .readout(readout), .readout_valid(readout_valid),
    .ext_hot_pin(ext_hot_pin), .force_power_reduce_pin(force_power_reduce_pin),
    .bidir_hot_enable(bidir_hot_enable), .msr_rd_en(msr_rd_en), .msr_wr_en(msr_wr_en),
    .msr_sel(msr_sel), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .msr_rd_valid(msr_rd_valid), .msr_fault(msr_fault), .lvt_mask_wr_en(lvt_mask_wr_en),
    .lvt_mask_wdata(lvt_mask_wdata), .lvt_thermal_masked(lvt_thermal_masked),
    .id_sensor_present(id_sensor_present), .id_thresh_count(id_thresh_count),
    .thermal_irq(thermal_irq));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [1:0] sel);
    @(posedge core_clk);
    msr_rd_en <= 1'b1;
    msr_sel   <= sel;
    @(posedge core_clk);
    msr_rd_en <= 1'b0;
    #1;
    rd_data = msr_rdata;
    rd_vld  = msr_rd_valid;
    rd_flt  = msr_fault;
  endtask : rd

  task automatic wr(input logic [1:0] sel, input logic [63:0] d);
    @(posedge core_clk);
    msr_wr_en <= 1'b1;
    msr_sel   <= sel;
    msr_wdata <= d;
    @(posedge core_clk);
    msr_wr_en <= 1'b0;
  endtask : wr

  // Moves the hot output and checks the interrupt one cycle later
  task automatic hot_irq(input logic val, input logic exp);
    @(posedge core_clk);
    sensor_hot <= val;
    @(posedge core_clk);
    #1;
    chk({63'h0, thermal_irq}, {63'h0, exp});
  endtask : hot_irq

  // Counts interrupt pulses over a window of clock cycles
  task automatic irq_win(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (thermal_irq === 1'b1) cnt++;
    end
  endtask : irq_win

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    rd(CT);
    chk(rd_data, 64'h0);
    chk({63'h0, rd_vld}, 64'h1);
    chk({63'h0, lvt_thermal_masked}, 64'h1);
    chk({59'h0, id_thresh_count, id_sensor_present},
        {59'h0, 4'(thermal_pkg::ID_THRESH_COUNT), 1'b1});
    rd(ST);
    chk(rd_data, RES);
    rd(2'h2);
    chk({rd_data[62:0], rd_flt}, 64'h1);
    $display("test reset done");
  endtask : test_reset

  task automatic test_hot;
    wr(CT, 64'h0080_8003);
    @(posedge core_clk);
    lvt_mask_wr_en <= 1'b1;
    lvt_mask_wdata <= 1'b0;
    @(posedge core_clk);
    lvt_mask_wr_en <= 1'b0;
    hot_irq(1'b1, 1'b1);
    rd(ST);
    chk(rd_data & 64'h3, 64'h3);
    wr(ST, 64'h0);
    rd(ST);
    chk(rd_data & 64'h3, 64'h3);
    hot_irq(1'b0, 1'b1);
    wr(ST, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(ST);
    chk(rd_data, RES | 64'h2);
    wr(ST, 64'h0);
    rd(ST);
    chk(rd_data & 64'h3, 64'h0);
    @(posedge core_clk);
    lvt_mask_wr_en <= 1'b1;
    lvt_mask_wdata <= 1'b1;
    @(posedge core_clk);
    lvt_mask_wr_en <= 1'b0;
    hot_irq(1'b1, 1'b0);
    hot_irq(1'b0, 1'b0);
    wr(ST, 64'h0);
    $display("test hot done");
  endtask : test_hot

  // Pins pass the agent flop and two synchroniser flops before the log
  task automatic test_pins;
    @(posedge core_clk);
    force_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ST);
    chk(rd_data & 64'hC, 64'hC);
    @(posedge core_clk);
    force_req <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(ST, 64'h0);
    rd(ST);
    chk(rd_data & 64'hC, 64'h0);
    @(posedge core_clk);
    hot_req <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ST);
    chk(rd_data & 64'hC, 64'h4);
    @(posedge core_clk);
    bidir_hot_enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(ST);
    chk(rd_data & 64'hC, 64'hC);
    @(posedge core_clk);
    hot_req          <= 1'b0;
    bidir_hot_enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(ST, 64'h0);
    $display("test pins done");
  endtask : test_pins

  task automatic test_levels;
    @(posedge core_clk);
    readout       <= 7'h14;
    readout_valid <= 1'b1;
    critical_temp <= 1'b1;
    // First threshold sits at the reading, second well beyond resolution plus one from it
    wr(CT, 64'h0085_9400);
    rd(CT);
    chk(rd_data, 64'h0085_9400);
    rd(ST);
    chk(rd_data, RES | 64'h8014_00F0);
    @(posedge core_clk);
    readout       <= 7'h15;
    critical_temp <= 1'b0;
    rd(ST);
    chk(rd_data, RES | 64'h8015_00A0);
    @(posedge core_clk);
    readout <= 7'h05;
    rd(ST);
    chk(rd_data, RES | 64'h8005_03E0);
    @(posedge core_clk);
    readout_valid <= 1'b0;
    rd(ST);
    chk(rd_data, RES | 64'h0005_02A0);
    wr(ST, 64'h0);
    rd(ST);
    chk(rd_data, RES | 64'h0005_0000);
    $display("test levels done");
  endtask : test_levels

  // Threshold, critical and pin sources in turn, one pulse or none expected per step
  task automatic test_irq;
    int n;
    @(posedge core_clk);
    readout        <= 7'h20;
    readout_valid  <= 1'b1;
    lvt_mask_wr_en <= 1'b1;
    lvt_mask_wdata <= 1'b0;
    @(posedge core_clk);
    lvt_mask_wr_en <= 1'b0;
    // Both thresholds well away from the reading, crossing interrupts on
    wr(CT, 64'h0005_141C);
    @(posedge core_clk);
    readout <= 7'h10;
    irq_win(3, n);
    chk(64'(n), 64'h1);
    @(posedge core_clk);
    readout <= 7'h05;
    irq_win(3, n);
    chk(64'(n), 64'h1);
    @(posedge core_clk);
    readout <= 7'h20;
    irq_win(3, n);
    chk(64'(n), 64'h1);
    @(posedge core_clk);
    critical_temp <= 1'b1;
    irq_win(3, n);
    chk(64'(n), 64'h1);
    @(posedge core_clk);
    critical_temp <= 1'b0;
    irq_win(3, n);
    chk(64'(n), 64'h0);
    @(posedge core_clk);
    force_req <= 1'b1;
    irq_win(6, n);
    chk(64'(n), 64'h1);
    @(posedge core_clk);
    hot_req <= 1'b1;
    irq_win(6, n);
    chk(64'(n), 64'h0);
    @(posedge core_clk);
    hot_req          <= 1'b0;
    bidir_hot_enable <= 1'b1;
    irq_win(6, n);
    chk(64'(n), 64'h0);
    @(posedge core_clk);
    hot_req <= 1'b1;
    irq_win(6, n);
    chk(64'(n), 64'h1);
    $display("test irq done");
  endtask : test_irq

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    test_reset;
    test_hot;
    test_pins;
    test_levels;
    test_irq;
    test_done;
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    test_done;
  end
endmodule : tb_digital_thermal_sensor_status
`default_nettype wire
